/* inc/sflash_cfg.svh */
// Opcodes, dummy counts, status bit positions and timing of the flash
`ifndef SFLASH_CFG_SVH
`define SFLASH_CFG_SVH
`define OP_WRITE_ENABLE   8'h06
`define OP_STATUS_WRITE   8'h01
`define OP_STATUS_READ    8'h05
`define OP_READ           8'h03
`define OP_FAST_READ      8'h0B
`define OP_DUAL_OUT       8'h3B
`define OP_DUAL_IO        8'hBB
`define OP_QUAD_OUT       8'h6B
`define DUMMY_NONE        4'h0
`define DUMMY_FAST        4'h8
`define DUMMY_DUAL_IO     4'h4
`define ADDR_BITS         24
`define CLK_PERIOD_NS     10
`define T_STATUS_WRITE_NS 10000
`define SR_SRP            7
`define SR_BP_HI          5
`define SR_BP_LO          2
`define SR_SECURE_SECTOR0_LOCK           7
`define SR_PIN_DIS        6
`define SR_SMALL_BOOT     4
`define SR_TOP_BOT        3
`endif

/* inc/sflash_pkg.sv */
// Types shared by the flash command logic
package sflash_pkg;
  typedef enum logic [3:0] {
    ST_CMD    = 4'b0000,
    ST_ADDR   = 4'b0001,
    ST_DUMMY  = 4'b0010,
    ST_DATA   = 4'b0011,
    ST_STAT   = 4'b0100,
    ST_SDATA  = 4'b0101,
    ST_WE_OK  = 4'b0110,
    ST_SW_OK  = 4'b0111,
    ST_IGNORE = 4'b1000
  } link_state_e;
  typedef enum logic [1:0] {
    LANE_1 = 2'b00,
    LANE_2 = 2'b01,
    LANE_4 = 2'b10
  } lane_e;
endpackage

/* rtl/sflash_cmd.sv */
// Serial flash status write and read command logic
`timescale 1ns/1ps
`default_nettype none
`include "sflash_cfg.svh"
// How it works
// - Sector zero lock set once unless volatile status is enabled
// - Status write needs write enable latch set
// - Status write never touches bits one, zero
// - Execute only if select rises after bit eight
// - Timed cycle holds busy, status stays readable
// - Cycle end clears write enable latch
// - Updates protect bits; refused in hardware protection
// - OTP mode sets four bits once; with volatile status enabled it rewrites them
// - Normal read: opcode, address, data on falls
// - Read address increments and wraps to zero
// - Select high stops driving, ends read
// - Reads rejected while a cycle runs
// - Fast read adds one dummy byte
// - Dual output: eight dummies, two lanes out
// - Dual I/O: address, dummy, data two lanes
// - Dual I/O address increments and wraps
// - Quad output: eight dummies, four lanes out
// - Quad output address increments and wraps
// - Hardware protection: protect bit and pin low
// - Pin disable bit ignores protect, hold pins
// - Bit zero busy, bit one latch (zero in OTP mode), read-only
module sflash_cmd #(
  parameter int unsigned MEM_AW    = `ADDR_BITS,
  parameter int unsigned TW_CYCLES =
    (`T_STATUS_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        otp_mode,
  input  wire logic        volatile_status_en,
  output logic             write_in_progress,
  output logic             write_enable_latch,
  output logic             status_protect_bit,
  output logic      [3:0]  block_protect,
  output logic             secure_sector0_lock,
  output logic             pin_disable_bit,
  output logic             small_boot_lock,
  output logic             top_bottom_select,
  output logic             hardware_protected_mode
);
  import sflash_pkg::*;

  localparam logic [23:0] ADDR_MASK = 24'((64'h1 << MEM_AW) - 64'h1);

  if (MEM_AW < 1 || MEM_AW > 24 || TW_CYCLES < 1) begin : g_bad_param
    $error("sflash_cmd: unsupported parameter values");
  end

  // Link side: frame tracking, cleared while select is high
  logic frame_rst;
  logic in_frame_reg;
  assign frame_rst = sys_rst | cs_n;

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // Link side synchronisers from the system domain
  logic       busy_s1_reg;
  logic       busy_s2_reg;
  logic       pin_disable_bit_s1_reg;
  logic       pin_disable_bit_s2_reg;
  logic [7:0] stat_s1_reg;
  logic [7:0] stat_s2_reg;
  logic [7:0] status_byte_reg;
  logic       wip_reg;
  logic [3:0] otp_reg;

  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      busy_s1_reg  <= 1'b0;
      busy_s2_reg  <= 1'b0;
      pin_disable_bit_s1_reg <= 1'b0;
      pin_disable_bit_s2_reg <= 1'b0;
      stat_s1_reg  <= 8'h00;
      stat_s2_reg  <= 8'h00;
    end else begin
      busy_s1_reg  <= wip_reg;
      busy_s2_reg  <= busy_s1_reg;
      pin_disable_bit_s1_reg <= otp_reg[2];
      pin_disable_bit_s2_reg <= pin_disable_bit_s1_reg;
      stat_s1_reg  <= status_byte_reg;
      stat_s2_reg  <= stat_s1_reg;
    end
  end

  // Command decoder, rising edges
  link_state_e state_reg;
  link_state_e state_next;
  link_state_e cur_state;
  lane_e       lanes_reg;
  lane_e       lanes_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  cnt_next;
  logic [4:0]  cur_cnt;
  logic [4:0]  data_last;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [23:0] addr_shift;
  logic [7:0]  op_reg;
  logic [7:0]  op_next;
  logic [7:0]  op_in;
  logic [7:0]  sdata_reg;
  logic [7:0]  sdata_next;
  logic        tog_reg;
  logic        tog_next;
  logic        addr_dual_reg;
  logic        addr_dual_next;
  logic [3:0]  dummy_reg;
  logic [3:0]  dummy_next;
  logic        hold_act;
  logic        rd_op;

  assign cur_state = in_frame_reg ? state_reg : ST_CMD;
  assign cur_cnt   = in_frame_reg ? cnt_reg : 5'h00;
  assign op_in     = {op_reg[6:0], io_in[0]};
  assign rd_op     = op_in == `OP_READ || op_in == `OP_FAST_READ ||
                     op_in == `OP_DUAL_OUT || op_in == `OP_DUAL_IO ||
                     op_in == `OP_QUAD_OUT;
  // Hold works only while pins are enabled and line 3 is not data
  assign hold_act  = !pin_disable_bit_s2_reg && !io_in[3] &&
                     !(state_reg == ST_DATA && lanes_reg == LANE_4);
  assign addr_shift = addr_dual_reg ? {addr_reg[21:0], io_in[1:0]}
                                    : {addr_reg[22:0], io_in[0]};
  assign data_last = (lanes_reg == LANE_4) ? 5'h01 :
                     (lanes_reg == LANE_2) ? 5'h03 : 5'h07;

  always_comb begin
    state_next     = cur_state;
    cnt_next       = cur_cnt;
    addr_next      = addr_reg;
    op_next        = op_reg;
    sdata_next     = sdata_reg;
    tog_next       = in_frame_reg ? tog_reg : ~tog_reg;
    lanes_next     = lanes_reg;
    addr_dual_next = addr_dual_reg;
    dummy_next     = dummy_reg;
    if (!hold_act) begin
      case (cur_state)
        ST_CMD: begin
          op_next  = op_in;
          cnt_next = cur_cnt + 5'h01;
          if (cur_cnt == 5'h07) begin
            cnt_next       = 5'h00;
            addr_dual_next = op_in == `OP_DUAL_IO;
            lanes_next     = (op_in == `OP_DUAL_OUT ||
                              op_in == `OP_DUAL_IO) ? LANE_2 :
                             (op_in == `OP_QUAD_OUT) ? LANE_4 : LANE_1;
            dummy_next     = (op_in == `OP_READ) ? `DUMMY_NONE :
                             (op_in == `OP_DUAL_IO) ? `DUMMY_DUAL_IO :
                             `DUMMY_FAST;
            if (op_in == `OP_WRITE_ENABLE) begin
              state_next = ST_WE_OK;
            end else if (op_in == `OP_STATUS_WRITE) begin
              state_next = ST_SDATA;
            end else if (op_in == `OP_STATUS_READ) begin
              state_next = ST_STAT;
              lanes_next = LANE_1;
            end else if (rd_op) begin
              state_next = busy_s2_reg ? ST_IGNORE : ST_ADDR;
            end else begin
              state_next = ST_IGNORE;
            end
          end
        end
        ST_ADDR: begin
          addr_next = addr_shift;
          cnt_next  = cur_cnt + 5'h01;
          if (cur_cnt == (addr_dual_reg ? 5'h0B : 5'h17)) begin
            addr_next  = addr_shift & ADDR_MASK;
            cnt_next   = 5'h00;
            state_next = (dummy_reg == `DUMMY_NONE) ? ST_DATA : ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Line 0 is don't care here
          cnt_next = cur_cnt + 5'h01;
          if (cur_cnt == {1'b0, dummy_reg} - 5'h01) begin
            cnt_next   = 5'h00;
            state_next = ST_DATA;
          end
        end
        ST_DATA: begin
          cnt_next = (cur_cnt == data_last) ? 5'h00 : cur_cnt + 5'h01;
          if (cur_cnt == 5'h00) begin
            addr_next = 24'(addr_reg + 24'h1) & ADDR_MASK;
          end
        end
        ST_STAT: begin
          cnt_next = {2'b00, cur_cnt[2:0] + 3'h1};
        end
        ST_SDATA: begin
          sdata_next = {sdata_reg[6:0], io_in[0]};
          cnt_next   = cur_cnt + 5'h01;
          if (cur_cnt == 5'h07) begin
            state_next = ST_SW_OK;
          end
        end
        ST_WE_OK: begin
          state_next = ST_IGNORE;
        end
        ST_SW_OK: begin
          state_next = ST_IGNORE;
        end
        default: begin
          state_next = ST_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= ST_IGNORE;
      cnt_reg       <= 5'h00;
      addr_reg      <= 24'h000000;
      op_reg        <= 8'h00;
      sdata_reg     <= 8'h00;
      tog_reg       <= 1'b0;
      lanes_reg     <= LANE_1;
      addr_dual_reg <= 1'b0;
      dummy_reg     <= 4'h0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      addr_reg      <= addr_next;
      op_reg        <= op_next;
      sdata_reg     <= sdata_next;
      tog_reg       <= tog_next;
      lanes_reg     <= lanes_next;
      addr_dual_reg <= addr_dual_next;
      dummy_reg     <= dummy_next;
    end
  end

  assign mem_addr = addr_reg;

  // Output shifter, falling edges
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [3:0] io_out_next;
  logic [3:0] io_oe_next;

  always_comb begin
    sh_next     = sh_reg;
    io_out_next = io_out;
    io_oe_next  = 4'h0;
    if (in_frame_reg && !hold_act &&
        (state_reg == ST_DATA || state_reg == ST_STAT)) begin
      if (cnt_reg == 5'h00) begin
        sh_next = (state_reg == ST_STAT) ? stat_s2_reg : mem_rdata;
      end else begin
        case (lanes_reg)
          LANE_2:  sh_next = {sh_reg[5:0], 2'b00};
          LANE_4:  sh_next = {sh_reg[3:0], 4'h0};
          default: sh_next = {sh_reg[6:0], 1'b0};
        endcase
      end
      case (lanes_reg)
        LANE_2: begin
          io_out_next = {2'b00, sh_next[7:6]};
          io_oe_next  = 4'h3;
        end
        LANE_4: begin
          io_out_next = sh_next[7:4];
          io_oe_next  = 4'hF;
        end
        default: begin
          io_out_next = {2'b00, sh_next[7], 1'b0};
          io_oe_next  = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      sh_reg <= 8'h00;
      io_out <= 4'h0;
      io_oe  <= 4'h0;
    end else begin
      sh_reg <= sh_next;
      io_out <= io_out_next;
      io_oe  <= io_oe_next;
    end
  end

  // System side: frame end detection and status register
  logic        cs_s1_reg;
  logic        cs_s2_reg;
  logic        cs_s3_reg;
  logic        we_s1_reg;
  logic        we_s2_reg;
  logic        sw_s1_reg;
  logic        sw_s2_reg;
  logic        tg_s1_reg;
  logic        tg_s2_reg;
  logic        wp_s1_reg;
  logic        wp_s2_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
      we_s1_reg <= 1'b0;
      we_s2_reg <= 1'b0;
      sw_s1_reg <= 1'b0;
      sw_s2_reg <= 1'b0;
      tg_s1_reg <= 1'b0;
      tg_s2_reg <= 1'b0;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      we_s1_reg <= state_reg == ST_WE_OK;
      we_s2_reg <= we_s1_reg;
      sw_s1_reg <= state_reg == ST_SW_OK;
      sw_s2_reg <= sw_s1_reg;
      tg_s1_reg <= tog_reg;
      tg_s2_reg <= tg_s1_reg;
      wp_s1_reg <= io_in[2];
      wp_s2_reg <= wp_s1_reg;
    end
  end

  logic        frame_end;
  logic        last_tg_reg;
  logic        wel_reg;
  logic        wel_next;
  logic        wip_next;
  logic [31:0] tw_cnt_reg;
  logic [31:0] tw_cnt_next;
  logic        srp_reg;
  logic        srp_next;
  logic [3:0]  bp_reg;
  logic [3:0]  bp_next;
  logic [3:0]  otp_next;
  logic [3:0]  otp_data;
  logic        hpm_reg;
  logic        hpm_next;
  logic [7:0]  status_byte_next;

  // Select rose and the frame has not been acted on yet
  assign frame_end = cs_s2_reg && !cs_s3_reg && (tg_s2_reg != last_tg_reg);
  assign otp_data  = {sdata_reg[`SR_SECURE_SECTOR0_LOCK], sdata_reg[`SR_PIN_DIS],
                      sdata_reg[`SR_SMALL_BOOT], sdata_reg[`SR_TOP_BOT]};

  always_comb begin
    wel_next    = wel_reg;
    wip_next    = wip_reg;
    tw_cnt_next = tw_cnt_reg;
    srp_next    = srp_reg;
    bp_next     = bp_reg;
    otp_next    = otp_reg;
    hpm_next    = srp_reg && !wp_s2_reg && !otp_reg[2];
    if (wip_reg) begin
      tw_cnt_next = tw_cnt_reg - 32'h1;
      if (tw_cnt_reg == 32'h1) begin
        wip_next = 1'b0;
        wel_next = 1'b0;
      end
    end
    if (frame_end && !wip_reg) begin
      if (we_s2_reg) begin
        wel_next = 1'b1;
      end
      if (sw_s2_reg && wel_reg && !hpm_reg) begin
        wip_next    = 1'b1;
        tw_cnt_next = TW_CYCLES;
        if (otp_mode && !volatile_status_en) begin
          otp_next = otp_reg | otp_data;
        end else if (otp_mode) begin
          otp_next = otp_data;
        end else begin
          srp_next = sdata_reg[`SR_SRP];
          bp_next  = sdata_reg[`SR_BP_HI:`SR_BP_LO];
        end
      end
    end
    status_byte_next = otp_mode ?
      {otp_reg[3], otp_reg[2], 1'b0, otp_reg[1], otp_reg[0], 2'b00, wip_reg} :
      {srp_reg, 1'b0, bp_reg, wel_reg, wip_reg};
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      last_tg_reg     <= 1'b0;
      wel_reg         <= 1'b0;
      wip_reg         <= 1'b0;
      tw_cnt_reg      <= 32'h0;
      srp_reg         <= 1'b0;
      bp_reg          <= 4'h0;
      otp_reg         <= 4'h0;
      hpm_reg         <= 1'b0;
      status_byte_reg <= 8'h00;
    end else begin
      last_tg_reg     <= frame_end ? tg_s2_reg : last_tg_reg;
      wel_reg         <= wel_next;
      wip_reg         <= wip_next;
      tw_cnt_reg      <= tw_cnt_next;
      srp_reg         <= srp_next;
      bp_reg          <= bp_next;
      otp_reg         <= otp_next;
      hpm_reg         <= hpm_next;
      status_byte_reg <= status_byte_next;
    end
  end

  assign write_in_progress       = wip_reg;
  assign write_enable_latch      = wel_reg;
  assign status_protect_bit      = srp_reg;
  assign block_protect           = bp_reg;
  assign secure_sector0_lock     = otp_reg[3];
  assign pin_disable_bit         = otp_reg[2];
  assign small_boot_lock         = otp_reg[1];
  assign top_bottom_select       = otp_reg[0];
  assign hardware_protected_mode = hpm_reg;

  // Checks
  chk_wel_needed: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(wip_reg) |-> $past(wel_reg)) else $error("write started without latch");
  chk_hpm_refuse: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(wip_reg) |-> !$past(hpm_reg)) else $error("write in protected mode");
  chk_cycle_end: assert property (@(posedge clock) disable iff (sys_rst)
    (wip_reg && tw_cnt_reg == 32'h1) |=> !wip_reg && !wel_reg)
    else $error("cycle end wrong");
  chk_cycle_len: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(wip_reg) |-> tw_cnt_reg == TW_CYCLES) else $error("cycle length wrong");
  chk_otp_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    !$past(otp_mode && volatile_status_en) |->
    ((otp_reg & $past(otp_reg)) == $past(otp_reg))) else $error("otp bit cleared");
  chk_prot_stable: assert property (@(posedge clock) disable iff (sys_rst)
    !$rose(wip_reg) |-> $stable(bp_reg) && $stable(srp_reg))
    else $error("protect bits changed");
  chk_low_bits: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 status_byte_reg[1:0] == {$past(otp_mode) ? 1'b0 : $past(wel_reg),
    $past(wip_reg)}) else $error("status low bits wrong");
  chk_oe_released: assert property (@(posedge clock) disable iff (sys_rst)
    cs_s2_reg |-> io_oe == 4'h0) else $error("driving while deselected");
  chk_busy_reject: assert property (@(posedge sck) disable iff (sys_rst)
    (in_frame_reg && state_reg == ST_CMD && cnt_reg == 5'h07 && !hold_act &&
    busy_s2_reg && rd_op) |=> state_reg == ST_IGNORE) else $error("busy read ran");
  chk_addr_step: assert property (@(posedge sck) disable iff (sys_rst)
    (in_frame_reg && state_reg == ST_DATA && cnt_reg == 5'h00 && !hold_act) |=>
    mem_addr == (24'($past(mem_addr) + 24'h1) & ADDR_MASK)) else $error("bad step");
  chk_quad_lanes: assert property (@(posedge sck) disable iff (sys_rst)
    (in_frame_reg && state_reg == ST_DATA && lanes_reg == LANE_4) |->
    io_oe == 4'hF) else $error("quad lanes not driven");
  cov_status_write: cover property (@(posedge clock) $rose(wip_reg));
  cov_write_enable: cover property (@(posedge clock) $rose(wel_reg));
  cov_quad_read: cover property (@(posedge sck)
    state_reg == ST_DATA && lanes_reg == LANE_4);
  cov_dual_io: cover property (@(posedge sck) state_reg == ST_DATA && addr_dual_reg);
endmodule // sflash_cmd
`default_nettype wire

/* dv/sflash_host.sv */
// Host serial flash controller model driving select, clock and lines
`timescale 1ns/1ps
`default_nettype none
module sflash_host (
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_val,
  input  wire logic [3:0] lines
);
  logic [3:0] drv;
  logic [3:0] hoe;
  logic       wp_level;
  logic [3:0] dv;

  // Released lines show the inverse of the last value
  assign dv     = {drv[3], wp_level, drv[1:0]};
  assign io_val = (hoe & dv) | (~hoe & ~dv);

  initial begin
    sck      = 1'b0;
    cs_n     = 1'b1;
    drv      = 4'hF;
    hoe      = 4'hF;
    wp_level = 1'b1;
  end

  task start;
    cs_n = 1'b0;
    drv  = 4'hF;
    hoe  = 4'hF;
    #62.5;
  endtask

  // MSB first, top lane carries the high bit; hold line stays high
  task send(input logic [31:0] v, input int clks, input int w);
    for (int i = clks - 1; i >= 0; i--) begin
      for (int j = 0; j < w; j++) drv[j] = v[i*w+j];
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask

  // Lines released for two or four lanes at the first data fall; sampled on rising clock
  task recv(output logic [7:0] b, input int w);
    if (w > 1) for (int j = 0; j < w; j++) hoe[j] = 1'b0;
    for (int i = 0; i < 8 / w; i++) begin
      #62.5;
      if (w == 1) b = {b[6:0], lines[1]};
      else for (int j = w - 1; j >= 0; j--) b = {b[6:0], lines[j]};
      sck = 1'b1;
      #62.5 sck = 1'b0;
    end
  endtask

  task stop;
    #62.5;
    cs_n = 1'b1;
    hoe  = 4'hF;
    drv  = 4'hF;
    #250;
  endtask
endmodule // sflash_host
`default_nettype wire

/* dv/serial_flash_status_write_and_reads_tb_top.sv */
// Testbench for the flash status write and read command logic
`timescale 1ns/1ps
`default_nettype none
`include "sflash_cfg.svh"
module serial_flash_status_write_and_reads_tb_top;
  logic        clock;
  logic        sys_rst;
  logic        otp_mode;
  logic        vol_en;
  wire         sck;
  wire         cs_n;
  wire  [3:0]  io_val;
  wire  [3:0]  io_in;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic [23:0] mem_addr;
  wire  [7:0]  mem_rdata;
  logic        write_in_progress;
  logic        write_enable_latch;
  logic        status_protect_bit;
  logic [3:0]  block_protect;
  logic        secure_sector0_lock;
  logic        pin_disable_bit;
  logic        small_boot_lock;
  logic        top_bottom_select;
  logic        hardware_protected_mode;
  int          n_fail;
  int          checks;

  assign io_in     = (io_oe & io_out) | (~io_oe & io_val);
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[23:16] ^ 8'hA5;

  function automatic logic [7:0] memv(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'hA5;
  endfunction

  sflash_host u_host (.sck(sck), .cs_n(cs_n), .io_val(io_val),
                      .lines(io_in));

  sflash_cmd #(.MEM_AW(24), .TW_CYCLES(1000)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .otp_mode(otp_mode),
    .volatile_status_en(vol_en), .write_in_progress(write_in_progress),
    .write_enable_latch(write_enable_latch),
    .status_protect_bit(status_protect_bit),
    .block_protect(block_protect),
    .secure_sector0_lock(secure_sector0_lock),
    .pin_disable_bit(pin_disable_bit), .small_boot_lock(small_boot_lock),
    .top_bottom_select(top_bottom_select),
    .hardware_protected_mode(hardware_protected_mode));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task rd(input logic [7:0] op, input logic [23:0] a, input int aw,
          input int dw, input int dum, input int n, input logic busy);
    logic [7:0]  b;
    logic [23:0] x;
    u_host.start;
    u_host.send({24'h0, op}, 8, 1);
    u_host.send({8'h0, a}, 24 / aw, aw);
    u_host.send(32'h0, dum, aw);
    for (int k = 0; k < n; k++) begin
      u_host.recv(b, dw);
      x = a + 24'(k);
      if (busy) cmp_byte({4'h0, io_oe}, 8'h00);
      else cmp_byte(b, memv(x));
    end
    u_host.stop;
    cmp_byte({4'h0, io_oe}, 8'h00);
  endtask

  task rdsr(input logic [7:0] exp);
    logic [7:0] b;
    u_host.start;
    u_host.send({24'h0, `OP_STATUS_READ}, 8, 1);
    u_host.recv(b, 1);
    u_host.stop;
    cmp_byte(b, exp);
  endtask

  task wait_wip(input logic v, input int lim);
    for (int i = 0; i < lim && write_in_progress !== v; i++)
      @(negedge clock);
  endtask

  task write_enable_cmd;
    u_host.start;
    u_host.send({24'h0, `OP_WRITE_ENABLE}, 8, 1);
    u_host.stop;
    repeat (10) @(negedge clock);
  endtask

  task wsr(input logic [7:0] d, input int extra, input logic ok);
    u_host.start;
    u_host.send({24'h0, `OP_STATUS_WRITE}, 8, 1);
    u_host.send({24'h0, d}, 8, 1);
    u_host.send(32'h0, extra, 1);
    u_host.stop;
    if (ok) begin
      wait_wip(1'b1, 20);
      cmp_bit(write_in_progress, 1'b1);
      cmp_bit(write_enable_latch, 1'b1);
    end else begin
      repeat (30) @(negedge clock);
      cmp_bit(write_in_progress, 1'b0);
    end
  endtask

  task done_cycle;
    wait_wip(1'b0, 1200);
    cmp_bit(write_in_progress, 1'b0);
    cmp_bit(write_enable_latch, 1'b0);
  endtask

  initial begin
    n_fail = 0;
    checks = 0;
    #300000;
    n_fail++;
    close_out;
  end

  initial begin
    sys_rst  = 1'b1;
    otp_mode = 1'b0;
    vol_en   = 1'b0;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    repeat (5) @(negedge clock);
    cmp_byte({write_in_progress, write_enable_latch, status_protect_bit,
              block_protect, hardware_protected_mode}, 8'h00);
    rd(`OP_READ, 24'hFFFFFE, 1, 1, `DUMMY_NONE, 3, 1'b0);
    rd(`OP_FAST_READ, 24'h123456, 1, 1, `DUMMY_FAST, 2, 1'b0);
    rd(`OP_DUAL_OUT, 24'hFFFFFF, 1, 2, `DUMMY_FAST, 2, 1'b0);
    rd(`OP_DUAL_IO, 24'hFFFFFF, 2, 2, `DUMMY_DUAL_IO, 2, 1'b0);
    rd(`OP_QUAD_OUT, 24'hFFFFFF, 1, 4, `DUMMY_FAST, 2, 1'b0);
    write_enable_cmd;
    cmp_bit(write_enable_latch, 1'b1);
    wsr(8'h3C, 0, 1'b1);
    rd(`OP_READ, 24'h000000, 1, 1, `DUMMY_NONE, 2, 1'b1);
    cmp_bit(write_in_progress, 1'b1);
    rdsr(8'h3F);
    done_cycle;
    cmp_byte({4'h0, block_protect}, 8'h0F);
    wsr(8'h00, 0, 1'b0);
    cmp_byte({4'h0, block_protect}, 8'h0F);
    write_enable_cmd;
    wsr(8'h00, 1, 1'b0);
    cmp_byte({4'h0, block_protect}, 8'h0F);
    wsr(8'h80, 0, 1'b1);
    done_cycle;
    cmp_byte({3'h0, status_protect_bit, block_protect}, 8'h10);
    u_host.wp_level = 1'b0;
    repeat (10) @(negedge clock);
    cmp_bit(hardware_protected_mode, 1'b1);
    write_enable_cmd;
    wsr(8'h3C, 0, 1'b0);
    cmp_byte({3'h0, status_protect_bit, block_protect}, 8'h10);
    u_host.wp_level = 1'b1;
    otp_mode = 1'b1;
    repeat (10) @(negedge clock);
    write_enable_cmd;
    wsr(8'hD8, 0, 1'b1);
    done_cycle;
    cmp_byte({4'h0, secure_sector0_lock, pin_disable_bit, small_boot_lock,
              top_bottom_select}, 8'h0F);
    write_enable_cmd;
    wsr(8'h00, 0, 1'b1);
    done_cycle;
    cmp_byte({4'h0, secure_sector0_lock, pin_disable_bit, small_boot_lock,
              top_bottom_select}, 8'h0F);
    u_host.wp_level = 1'b0;
    repeat (10) @(negedge clock);
    cmp_bit(hardware_protected_mode, 1'b0);
    vol_en = 1'b1;
    write_enable_cmd;
    wsr(8'h40, 0, 1'b1);
    done_cycle;
    cmp_byte({4'h0, secure_sector0_lock, pin_disable_bit, small_boot_lock,
              top_bottom_select}, 8'h04);
    close_out;
  end
endmodule // serial_flash_status_write_and_reads_tb_top
`default_nettype wire
